// File: can_rx_message_assembly_tb.sv
// Testbench for the receive message assembly block.
`timescale 1ns/1ps
module can_rx_message_assembly_tb;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_valid, rx_ready;
  logic rx_ide, rx_rtr, mem_req, mem_gnt, evt_done, evt_warn, evt_full;
  logic evt_err;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [4:0] rx_obj, evt_obj;
  logic [28:0] rx_id;
  logic [3:0] rx_dlc, delay;
  logic [63:0] rx_data;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  int failures, n_compared, cyc, n_done, n_err, n_full, n_warn;
  int w0, d0, e0, f0, v0;

  cra_msg_assembly dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_obj(rx_obj), .rx_id(rx_id), .rx_ide(rx_ide),
    .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_gnt(mem_gnt), .evt_done(evt_done), .evt_warn(evt_warn),
    .evt_full(evt_full), .evt_err(evt_err), .evt_obj(evt_obj));
  cra_mem_model mem_u (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_gnt(mem_gnt),
    .delay(delay));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Event counters and the run time limit.
  always @(posedge hclk)
  begin
    cyc++;
    if (evt_done === 1'b1) n_done++;
    if (evt_err === 1'b1) n_err++;
    if (evt_full === 1'b1) n_full++;
    if (evt_warn === 1'b1) n_warn++;
    if (cyc == 30000)
    begin
      failures++;
      end_of_test;
    end
  end

  // ==========================================================
  // Tasks
  task end_of_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task check(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task ahb(input [31:0] a, input w, input [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task wr(input [31:0] a, input [31:0] d);
    ahb(a, 1'b1, d);
  endtask

  task rd_chk(input [31:0] a, input [31:0] e);
    ahb(a, 1'b0, 32'h0);
    check(hrdata, e);
  endtask

  task cfg(input [4:0] o, input [31:0] ctl, input [31:0] bsz,
    input [31:0] base);
    wr({22'h0, o, 5'h10}, ctl);
    wr({22'h0, o, 5'h14}, bsz);
    wr({22'h0, o, 5'h18}, base);
  endtask

  task send(input [4:0] o, input [3:0] d, input [63:0] x);
    rx_obj <= o;
    rx_dlc <= d;
    rx_data <= x;
    rx_valid <= 1'b1;
    @(posedge hclk);
    while (rx_ready !== 1'b1) @(posedge hclk);
    rx_valid <= 1'b0;
    @(posedge hclk);
    while (rx_ready !== 1'b1) @(posedge hclk);
    repeat (3) @(posedge hclk);
  endtask

  // ==========================================================
  // Test sequence
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, rx_valid} = '0;
    {rx_obj, rx_dlc, rx_data} = '0;
    {failures, n_compared, cyc, n_done, n_err, n_full, n_warn} = '0;
    rx_id = 29'h15a5c3e7;
    rx_ide = 1'b1;
    rx_rtr = 1'b0;
    delay = 4'h2;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int p = 3; p >= 0; p--)
    begin
      wr(32'h400, p);
      rd_chk(32'h400, p);
    end
    $display("test protocol codes done");
    wr(32'h8, 32'h00ff);
    wr(32'hc, 32'hfffc);
    cfg(5'd0, 32'h0, 32'h3, 32'h40);
    w0 = mem_u.n_wr;
    send(5'd0, 4'd3, 64'h332211);
    check(mem_u.mem[12'h40], 8'h83);
    for (int k = 1; k < 4; k++)
      check(mem_u.mem[12'h40 + k], 8'h11 * k);
    check(mem_u.n_wr - w0, 4);
    rd_chk(32'h0, {24'h0, rx_id[20:13]});
    rd_chk(32'h4, {16'h0, rx_id[12:0], 3'b100});
    rx_rtr <= 1'b1;
    send(5'd0, 4'd3, 64'h0);
    check(mem_u.mem[12'h40], 8'hc3);
    check(mem_u.mem[12'h41], 8'h11);
    rx_rtr <= 1'b0;
    $display("test single frame done");
    wr(32'h400, 32'h1);
    wr(32'h28, 32'h0);
    wr(32'h2c, 32'h0);
    cfg(5'd1, 32'h2, 32'h5, 32'h100);
    delay <= 4'h0;
    w0 = mem_u.n_wr;
    d0 = n_done;
    send(5'd1, 4'd4, 64'h03020100);
    send(5'd1, 4'd8, 64'h0a09080706050441);
    send(5'd1, 4'd2, 64'h0b82);
    for (int k = 1; k < 12; k++)
      check(mem_u.mem[12'h100 + k], k);
    check(mem_u.mem[12'h100], 8'h0b);
    check(mem_u.n_wr - w0, 13);
    check(n_done - d0, 1);
    check(evt_obj, 32'h1);
    $display("test fragmented message done");
    e0 = n_err;
    d0 = n_done;
    delay <= 4'h2;
    send(5'd1, 4'd2, 64'h5500);
    send(5'd1, 4'd2, 64'h6645);
    check(n_err - e0, 1);
    send(5'd1, 4'd2, 64'h7741);
    check(mem_u.mem[12'h100], 8'h00);
    check(mem_u.mem[12'h101], 8'h77);
    check(n_done - d0, 0);
    $display("test sequence error done");
    wr(32'h400, 32'h2);
    wr(32'h7c, 32'h0);
    cfg(5'd3, 32'h2, 32'h5, 32'h300);
    d0 = n_done;
    e0 = n_err;
    send(5'd3, 4'd2, 64'h1100);
    send(5'd3, 4'd2, 64'h2211);
    check(mem_u.mem[12'h301], 8'h22);
    check(mem_u.mem[12'h300], 8'h02);
    check(n_done - d0, 1);
    send(5'd3, 4'd2, 64'h3310);
    check(n_err - e0, 1);
    $display("test toggle fragments done");
    wr(32'h400, 32'h3);
    wr(32'h5c, 32'h0);
    cfg(5'd2, 32'h2, 32'h2, 32'h200);
    w0 = mem_u.n_wr;
    d0 = n_done;
    v0 = n_warn;
    f0 = n_full;
    send(5'd2, 4'd4, 64'h03020100);
    send(5'd2, 4'd4, 64'h06050401);
    check(mem_u.n_wr - w0, 6);
    check(n_done - d0, 0);
    rd_chk(32'h5c, 32'h2);
    send(5'd2, 4'd5, 64'h0a09080702);
    check(mem_u.mem[12'h207], 8'h08);
    check(mem_u.mem[12'h201], 8'h09);
    check(mem_u.mem[12'h200], 8'h0a);
    check(n_full - f0, 1);
    check(n_warn - v0, 1);
    check(n_done - d0, 0);
    check(evt_obj, 32'h2);
    $display("test osek fragments done");
    wr(32'h400, 32'h0);
    cfg(5'd1, 32'h2, 32'h3, 32'h100);
    w0 = mem_u.n_wr;
    e0 = n_err;
    f0 = n_full;
    send(5'd1, 4'd2, 64'h0045);
    send(5'd1, 4'd2, 64'h0000);
    check(mem_u.n_wr - w0, 6);
    check(n_err - e0, 0);
    check(n_full - f0, 0);
    send(5'd1, 4'd2, 64'h0000);
    check(n_full - f0, 1);
    $display("test plain frame buffering done");
    end_of_test;
  end
endmodule // can_rx_message_assembly_tb

// File: cra_defines.vh
// Constants for the receive message assembly block.
`ifndef CRA_DEFINES_VH
`define CRA_DEFINES_VH
// ==========================================================
// Register map
`define CRA_GLB_BIT 10
`define CRA_GCTL_OFS 12'h400
`define CRA_STAT_OFS 12'h404
`define CRA_R_MIDH 3'h0
`define CRA_R_MIDL 3'h1
`define CRA_R_MSKH 3'h2
`define CRA_R_MSKL 3'h3
`define CRA_R_CTL 3'h4
`define CRA_R_BSZ 3'h5
`define CRA_R_BLR 3'h6
`define CRA_R_FCR 3'h7
`define CRA_MIDL_MASK 16'hfffc
`define CRA_CTL_FRAGMENT_ASSEMBLY_ENABLE 1
// ==========================================================
// Protocol codes
`define CRA_P_CAN 2'h0
`define CRA_P_DNET 2'h1
`define CRA_P_COPEN 2'h2
`define CRA_P_OSEK 2'h3
// ==========================================================
// Buffer figures
`define CRA_FULL_LEFT 9'h009
`define CRA_WARN_LEFT 9'h008
`define CRA_MAX_DATA 4'h8
`define CRA_FIRST_OFS 8'h01
// ==========================================================
// Assembly states
`define CRA_S_IDLE 3'h0
`define CRA_S_CHECK 3'h1
`define CRA_S_SEM 3'h2
`define CRA_S_INFO 3'h3
`define CRA_S_DATA 3'h4
`define CRA_S_END 3'h5
`define CRA_S_COUNT 3'h6
`endif

// File: cra_fragment_assembly_enable_decode.v
// Fragmentation byte decoder for one received frame.
`timescale 1ns/1ps
`include "cra_defines.vh"
module cra_fragment_assembly_enable_decode (
  // Configuration and state
  input wire [1:0] proto,
  input wire [5:0] fcr,
  // Fragmentation byte
  input wire [7:0] fbyte,
  // Decode result
  output reg first,
  output reg last,
  output reg seq_ok,
  output reg [5:0] fcr_next
);
  always @*
  begin
    first = 1'b0;
    last = 1'b0;
    seq_ok = 1'b1;
    fcr_next = fcr;
    case (proto)
      `CRA_P_DNET:
      begin
        first = (fbyte[7:6] == 2'h0);
        last = (fbyte[7:6] == 2'h2);
        seq_ok = first | (fbyte[5:0] == fcr);
        fcr_next = fbyte[5:0] + 6'h01;
      end
      `CRA_P_COPEN:
      begin
        last = fbyte[0];
        seq_ok = (fbyte[4] == fcr[0]);
        fcr_next = {5'h00, ~fbyte[4]};
      end
      `CRA_P_OSEK:
      begin
        seq_ok = (fbyte[3:0] == fcr[3:0]);
        fcr_next = {2'h0, fbyte[3:0] + 4'h1};
      end
      default:
      begin
        seq_ok = 1'b1;
      end
    endcase
  end
endmodule // cra_fragment_assembly_enable_decode

// File: cra_mem_model.sv
// Behavioural message memory with a programmable grant delay.
`timescale 1ns/1ps
module cra_mem_model (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Byte write port
  input wire mem_req,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  output wire mem_gnt,
  // Stall cycles before each grant
  input wire [3:0] delay
);
  logic [7:0] mem [0:4095];
  logic [3:0] cnt_reg;
  int n_wr;
  // Grant only after the requested number of stall cycles.
  assign mem_gnt = mem_req && (cnt_reg >= delay);
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= 4'h0;
      n_wr <= 0;
    end
    else if (mem_req && mem_gnt)
    begin
      mem[mem_addr[11:0]] <= mem_wdata;
      n_wr <= n_wr + 1;
      cnt_reg <= 4'h0;
    end
    else if (mem_req)
    begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule // cra_mem_model

// File: cra_msg_assembly.v
// Receive message assembly with AHB-Lite register access and byte DMA.
//
// How it works
// - Single-frame objects get the received identifier written back after DMA.
// - Write-back only touches identifier bits that the mask leaves free.
// - Frame info byte: IDE, RTR, two semaphore bits, length code.
// - High word holds ID 28..13; low word ID 12..0 then IDE.
// - Fragment objects never store the identifier in the buffer.
// - Data of each later fragment follows the bytes already stored.
// - Transport protocols drop the first data byte, the fragment byte.
// - Plain CAN buffering stores whole frames; full below nine left.
// - Plain CAN wrap restarts at offset one, no byte count.
// - Addresses climb from base and wrap at size-derived top.
// - A warning event fires at eight bytes left; never for single-frame objects.
// - Up to 32 objects reassemble independently from data byte one.
// - Per object pointer and count; end writes count then signals.
// - At most seven bytes per transport protocol frame; base holds data byte total.
// - Fragment byte gives first, middle, last and sequence or toggle.
// - Error only on sequence not plus one or toggle not alternating.
// - On error pointer and count reset and an error event fires.
// - Plain CAN protocol disables all fragmentation checks.
// - DeviceNet first frame writes zero to base; never for CANopen or OSEK objects.
// - OSEK gives no completion; only buffer full with count write.
// - Protocol field: CAN, DeviceNet, CANopen, OSEK.
// - Buffer size field gives two up to 256 bytes, doubling.
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "cra_defines.vh"
module cra_msg_assembly #(
  parameter NOBJ = 32,
  parameter OBJ_W = 5
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // Accepted frame from the receive pre-buffer
  input wire rx_valid,
  output wire rx_ready,
  input wire [OBJ_W-1:0] rx_obj,
  input wire [28:0] rx_id,
  input wire rx_ide,
  input wire rx_rtr,
  input wire [3:0] rx_dlc,
  input wire [63:0] rx_data,
  // Byte write port to message memory
  output reg mem_req,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire mem_gnt,
  // Event pulses for the CPU interrupt logic
  output reg evt_done,
  output reg evt_warn,
  output reg evt_full,
  output reg evt_err,
  output reg [OBJ_W-1:0] evt_obj
);
  // ==========================================================
  // Per object state and the global control register
  reg [15:0] midh_reg [0:NOBJ-1];
  reg [15:0] midl_reg [0:NOBJ-1];
  reg [15:0] mskh_reg [0:NOBJ-1];
  reg [15:0] mskl_reg [0:NOBJ-1];
  reg [4:0] ctl_reg [0:NOBJ-1];
  reg [2:0] bsz_reg [0:NOBJ-1];
  reg [15:0] blr_reg [0:NOBJ-1];
  reg [5:0] fcr_reg [0:NOBJ-1];
  reg [7:0] ptr_reg [0:NOBJ-1];
  reg [7:0] cnt_reg [0:NOBJ-1];
  reg [1:0] gctl_reg;
  // ==========================================================
  // Frame latch, sequencer and bus slave registers
  reg [2:0] state_reg;
  reg [OBJ_W-1:0] f_obj_reg;
  reg [28:0] f_id_reg;
  reg f_ide_reg;
  reg f_rtr_reg;
  reg [3:0] f_dlc_reg;
  reg [63:0] f_data_reg;
  reg [3:0] idx_reg;
  reg [3:0] nbytes_reg;
  reg last_reg;
  reg wrapped_reg;
  reg [5:0] fcr_upd_reg;
  reg [31:0] rdata_reg;
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;
  integer i;

  wire fragment_assembly_enable = ctl_reg[f_obj_reg][`CRA_CTL_FRAGMENT_ASSEMBLY_ENABLE];
  wire [1:0] proto = gctl_reg;
  wire tl_fragment_assembly_enable = fragment_assembly_enable & (proto != `CRA_P_CAN);
  wire [7:0] cur_ptr = ptr_reg[f_obj_reg];
  wire [7:0] cur_cnt = cnt_reg[f_obj_reg];
  wire [15:0] base = blr_reg[f_obj_reg];
  wire [8:0] bsize = 9'h002 << bsz_reg[f_obj_reg];
  wire [8:0] left = bsize - {1'b0, cur_ptr};
  wire [8:0] ptr_inc = {1'b0, cur_ptr} + 9'h001;
  wire at_top = (ptr_inc == bsize);
  wire [7:0] ptr_adv = at_top ? `CRA_FIRST_OFS : ptr_inc[7:0];
  wire [7:0] cur_byte = f_data_reg[{idx_reg[2:0], 3'h0} +: 8];
  wire [3:0] dlc_cl = (f_dlc_reg > `CRA_MAX_DATA) ? `CRA_MAX_DATA :
                      f_dlc_reg;
  wire dec_first;
  wire dec_last;
  wire dec_ok;
  wire [5:0] dec_fcr;

  cra_fragment_assembly_enable_decode u_dec (
    .proto(proto),
    .fcr(fcr_reg[f_obj_reg]),
    .fbyte(f_data_reg[7:0]),
    .first(dec_first),
    .last(dec_last),
    .seq_ok(dec_ok),
    .fcr_next(dec_fcr)
  );

  // ==========================================================
  // Bus slave, zero wait states
  wire bus_go = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign rx_ready = (state_reg == `CRA_S_IDLE);

  wire [OBJ_W-1:0] r_obj = haddr[OBJ_W+4:5];
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (haddr[31:11] != 21'h000000)
      rd_mux = 32'h0000_0000;
    else if (haddr[`CRA_GLB_BIT])
    begin
      if (haddr[11:0] == `CRA_GCTL_OFS)
        rd_mux = {30'h0, gctl_reg};
      else if (haddr[11:0] == `CRA_STAT_OFS)
        rd_mux = {24'h0, state_reg, f_obj_reg};
    end
    else
    begin
      case (haddr[4:2])
        `CRA_R_MIDH: rd_mux = {16'h0, midh_reg[r_obj]};
        `CRA_R_MIDL: rd_mux = {16'h0, midl_reg[r_obj]};
        `CRA_R_MSKH: rd_mux = {16'h0, mskh_reg[r_obj]};
        `CRA_R_MSKL: rd_mux = {16'h0, mskl_reg[r_obj]};
        `CRA_R_CTL: rd_mux = {27'h0, ctl_reg[r_obj]};
        `CRA_R_BSZ: rd_mux = {29'h0, bsz_reg[r_obj]};
        `CRA_R_BLR: rd_mux = {16'h0, blr_reg[r_obj]};
        default: rd_mux = {26'h0, fcr_reg[r_obj]};
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_reg <= 32'h0000_0000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end
    else
    begin
      wr_pend_reg <= bus_go & hwrite & (haddr[31:11] == 21'h000000);
      wr_addr_reg <= haddr[11:0];
      if (bus_go & ~hwrite)
        rdata_reg <= rd_mux;
    end
  end

  // ==========================================================
  // Register storage: bus writes, then the sequencer wins on a clash
  wire [OBJ_W-1:0] w_obj = wr_addr_reg[OBJ_W+4:5];
  wire gw = wr_pend_reg & wr_addr_reg[`CRA_GLB_BIT];
  wire ow = wr_pend_reg & ~wr_addr_reg[`CRA_GLB_BIT];
  wire [2:0] wsel = wr_addr_reg[4:2];

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 0; i < NOBJ; i = i + 1)
      begin
        midh_reg[i] <= 16'h0000;
        midl_reg[i] <= 16'h0000;
        mskh_reg[i] <= 16'h0000;
        mskl_reg[i] <= 16'h0000;
        ctl_reg[i] <= 5'h00;
        bsz_reg[i] <= 3'h0;
        blr_reg[i] <= 16'h0000;
        fcr_reg[i] <= 6'h00;
        ptr_reg[i] <= `CRA_FIRST_OFS;
        cnt_reg[i] <= 8'h00;
      end
      gctl_reg <= `CRA_P_CAN;
      state_reg <= `CRA_S_IDLE;
      f_obj_reg <= {OBJ_W{1'b0}};
      f_id_reg <= 29'h0;
      f_ide_reg <= 1'b0;
      f_rtr_reg <= 1'b0;
      f_dlc_reg <= 4'h0;
      f_data_reg <= 64'h0;
      idx_reg <= 4'h0;
      nbytes_reg <= 4'h0;
      last_reg <= 1'b0;
      wrapped_reg <= 1'b0;
      fcr_upd_reg <= 6'h00;
      mem_req <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      evt_done <= 1'b0;
      evt_warn <= 1'b0;
      evt_full <= 1'b0;
      evt_err <= 1'b0;
      evt_obj <= {OBJ_W{1'b0}};
    end
    else
    begin
      evt_done <= 1'b0;
      evt_warn <= 1'b0;
      evt_full <= 1'b0;
      evt_err <= 1'b0;
      if (gw && wr_addr_reg == `CRA_GCTL_OFS)
        gctl_reg <= hwdata[1:0];
      if (ow)
      begin
        case (wsel)
          `CRA_R_MIDH: midh_reg[w_obj] <= hwdata[15:0];
          `CRA_R_MIDL: midl_reg[w_obj] <= hwdata[15:0] & `CRA_MIDL_MASK;
          `CRA_R_MSKH: mskh_reg[w_obj] <= hwdata[15:0];
          `CRA_R_MSKL: mskl_reg[w_obj] <= hwdata[15:0] & `CRA_MIDL_MASK;
          `CRA_R_CTL: ctl_reg[w_obj] <= hwdata[4:0];
          `CRA_R_BSZ: bsz_reg[w_obj] <= hwdata[2:0];
          `CRA_R_BLR:
          begin
            blr_reg[w_obj] <= hwdata[15:0];
            ptr_reg[w_obj] <= 8'h00;
            cnt_reg[w_obj] <= 8'h00;
          end
          default: fcr_reg[w_obj] <= hwdata[5:0];
        endcase
      end
      case (state_reg)
        `CRA_S_IDLE:
        begin
          if (rx_valid)
          begin
            f_obj_reg <= rx_obj;
            f_id_reg <= rx_id;
            f_ide_reg <= rx_ide;
            f_rtr_reg <= rx_rtr;
            f_dlc_reg <= rx_dlc;
            f_data_reg <= rx_data;
            wrapped_reg <= 1'b0;
            state_reg <= `CRA_S_CHECK;
          end
        end
        `CRA_S_CHECK:
        begin
          nbytes_reg <= f_rtr_reg ? 4'h0 : dlc_cl;
          last_reg <= dec_last;
          fcr_upd_reg <= dec_fcr;
          idx_reg <= tl_fragment_assembly_enable ? 4'h1 : 4'h0;
          if (!fragment_assembly_enable)
          begin
            ptr_reg[f_obj_reg] <= 8'h00;
            state_reg <= `CRA_S_INFO;
          end
          else if (!tl_fragment_assembly_enable)
            state_reg <= `CRA_S_INFO;
          else if (!dec_ok)
          begin
            ptr_reg[f_obj_reg] <= `CRA_FIRST_OFS;
            cnt_reg[f_obj_reg] <= 8'h00;
            evt_err <= 1'b1;
            evt_obj <= f_obj_reg;
            state_reg <= `CRA_S_IDLE;
          end
          else if (dec_first)
          begin
            ptr_reg[f_obj_reg] <= `CRA_FIRST_OFS;
            cnt_reg[f_obj_reg] <= 8'h00;
            state_reg <= `CRA_S_SEM;
          end
          else
            state_reg <= `CRA_S_DATA;
        end
        `CRA_S_SEM:
        begin
          mem_req <= 1'b1;
          mem_addr <= base;
          mem_wdata <= 8'h00;
          if (mem_req && mem_gnt)
          begin
            mem_req <= 1'b0;
            state_reg <= `CRA_S_DATA;
          end
        end
        `CRA_S_INFO:
        begin
          mem_req <= 1'b1;
          mem_addr <= base + {8'h00, cur_ptr};
          mem_wdata <= {f_ide_reg, f_rtr_reg, 2'h0, f_dlc_reg};
          if (mem_req && mem_gnt)
          begin
            mem_req <= 1'b0;
            ptr_reg[f_obj_reg] <= ptr_adv;
            state_reg <= `CRA_S_DATA;
          end
        end
        `CRA_S_DATA:
        begin
          if (idx_reg >= nbytes_reg)
          begin
            mem_req <= 1'b0;
            state_reg <= `CRA_S_END;
          end
          else
          begin
            mem_req <= 1'b1;
            mem_addr <= base + {8'h00, cur_ptr};
            mem_wdata <= cur_byte;
            if (mem_req && mem_gnt)
            begin
              mem_req <= 1'b0;
              idx_reg <= idx_reg + 4'h1;
              ptr_reg[f_obj_reg] <= ptr_adv;
              cnt_reg[f_obj_reg] <= cur_cnt + 8'h01;
              if (fragment_assembly_enable && left == `CRA_WARN_LEFT)
              begin
                evt_warn <= 1'b1;
                evt_obj <= f_obj_reg;
              end
              if (at_top)
                wrapped_reg <= 1'b1;
            end
          end
        end
        `CRA_S_END:
        begin
          state_reg <= `CRA_S_IDLE;
          evt_obj <= f_obj_reg;
          if (!fragment_assembly_enable)
          begin
            midh_reg[f_obj_reg] <= (midh_reg[f_obj_reg] &
              ~mskh_reg[f_obj_reg]) | (f_id_reg[28:13] & mskh_reg[f_obj_reg]);
            midl_reg[f_obj_reg] <= ((midl_reg[f_obj_reg] &
              ~mskl_reg[f_obj_reg]) | ({f_id_reg[12:0], f_ide_reg, 2'h0} &
              mskl_reg[f_obj_reg])) & `CRA_MIDL_MASK;
            evt_done <= 1'b1;
          end
          else if (!tl_fragment_assembly_enable)
          begin
            if (left < `CRA_FULL_LEFT)
              evt_full <= 1'b1;
          end
          else
          begin
            fcr_reg[f_obj_reg] <= fcr_upd_reg;
            if (proto == `CRA_P_OSEK ? wrapped_reg : last_reg)
              state_reg <= `CRA_S_COUNT;
          end
        end
        `CRA_S_COUNT:
        begin
          mem_req <= 1'b1;
          mem_addr <= base;
          mem_wdata <= cur_cnt;
          if (mem_req && mem_gnt)
          begin
            mem_req <= 1'b0;
            ptr_reg[f_obj_reg] <= `CRA_FIRST_OFS;
            cnt_reg[f_obj_reg] <= 8'h00;
            evt_obj <= f_obj_reg;
            if (proto == `CRA_P_OSEK)
              evt_full <= 1'b1;
            else
              evt_done <= 1'b1;
            state_reg <= `CRA_S_IDLE;
          end
        end
        default:
          state_reg <= `CRA_S_IDLE;
      endcase
    end
  end
endmodule // cra_msg_assembly

// File: cra_msg_assembly_chk.sv
// Port assertions for the receive message assembly block.
`timescale 1ns/1ps
module cra_msg_assembly_chk #(
  parameter NOBJ = 32,
  parameter OBJ_W = 5
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Observed ports
  input wire hreadyout,
  input wire hresp,
  input wire rx_valid,
  input wire rx_ready,
  input wire mem_req,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire mem_gnt,
  input wire evt_done,
  input wire evt_full,
  input wire evt_err
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // Properties
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_req_held: assert property (mem_req && !mem_gnt |=> mem_req
    && $stable(mem_addr) && $stable(mem_wdata))
    else $error("byte request changed before grant");
  a_req_gap: assert property (mem_req && mem_gnt |=> !mem_req)
    else $error("byte request without idle cycle");
  a_rx_busy: assert property (rx_valid && rx_ready |=> !rx_ready)
    else $error("frame port ready while busy");
  a_dma_busy: assert property (mem_req |-> !rx_ready)
    else $error("frame port ready during memory transfer");
  a_done_pulse: assert property (evt_done |=> !evt_done)
    else $error("completion pulse longer than one cycle");
  a_err_pulse: assert property (evt_err |=> !evt_err)
    else $error("error pulse longer than one cycle");
  a_err_alone: assert property (evt_err |-> !evt_done && !evt_full)
    else $error("error pulse together with another event");
  a_done_quiet: assert property (evt_done |-> !mem_req)
    else $error("completion before memory transfers ended");
endmodule // cra_msg_assembly_chk

bind cra_msg_assembly cra_msg_assembly_chk #(.NOBJ(NOBJ), .OBJ_W(OBJ_W))
  chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
  .hresp(hresp), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_gnt(mem_gnt), .evt_done(evt_done), .evt_full(evt_full),
  .evt_err(evt_err));
